//--- design/viu_pkg.sv
// Shared constants for the vectored interrupt unit
package viu_pkg;
    localparam int          VIU_NUM_SRC      = 10;
    localparam int          VIU_NUM_MASK     = 8;
    localparam int          VIU_PC_W         = 15;
    localparam logic [7:0]  VIU_TRAP_OPCODE  = 8'h00;
    localparam logic [14:0] VIU_ENTRY_ADDR   = 15'h00ff;
    localparam logic [7:0]  VIU_TABLE_BASE   = 8'he0;
    localparam logic [7:0]  VIU_PAGE_LAST    = 8'hff;
    localparam logic [2:0]  VIU_PUSH_CNT     = 3'h2;
    localparam logic [2:0]  VIU_BRANCH_CNT   = 3'h5;
    // Vector slot per rank (slot 0 is default, rising with rank)
    localparam logic [3:0]  VIU_SLOT_TRAP    = 4'hf;
    localparam logic [3:0]  VIU_SLOT_DEFAULT = 4'h0;
    localparam logic [31:0] VIU_SLOT_TABLE   = 32'h1459abcd;
    // Register offsets
    localparam logic [3:0]  VIU_REG_ENABLE   = 4'h0;
    localparam logic [3:0]  VIU_REG_PENDING  = 4'h4;
    localparam logic [3:0]  VIU_REG_CTRL     = 4'h8;
    localparam logic [3:0]  VIU_REG_STATUS   = 4'hc;
    localparam int          VIU_CTRL_GIE_BIT = 0;
    localparam logic [7:0]  VIU_ENABLE_RST   = 8'h00;
    localparam logic [7:0]  VIU_PENDING_RST  = 8'h00;
    localparam logic        VIU_GIE_RST      = 1'b0;
endpackage

//--- design/viu_core.sv
// Vectored interrupt unit: arbitration, entry sequence and vector fetch
//
// Contract
// - Ten sources, each with its own vector slot, ranked by fixed priority.
// - A maskable source is active only when enabled and pending.
// - With global enable set and a source active, interrupt at next instruction start.
// - Interruption jams trap opcode 00 into the instruction register.
// - Each maskable entry clears global enable; every entry pushes PC, branches to 00FF within 7 cycles.
// - Global enable clear blocks every maskable interrupt.
// - Vector select samples active sources and jumps to the highest-ranked.
// - Passed-over sources stay pending and interrupt again right after return.
// - Hardware never clears a maskable pending bit; the routine clears it.
// - Return-from-interrupt sets the global enable again.
// - Vector is 15 bits in two bytes, high byte at lower address.
// - Table lies in the vector select page, or next page from last address.
// - Slots are two bytes apart, rising from the lowest slot with rank.
// - Rank: trap, edge pin, idle timer, T1A, T1B, serial, T2A, T2B, wakeup, default.
// - Edge pin source takes vector from FA and FB of the page.
// - Software trap ranks highest, vector at FE and FF.
// - Vector select with nothing active branches through E0-E1.
// - Fetching the trap opcode from memory raises a software trap.
// - Trap sets a hidden pending flag, keeps global enable, blocks others, steers select.
// - Trap pending flag cleared by clear-trap-pending instruction and by reset.
// - While a trap is serviced only another trap may interrupt.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module viu_core #(
    parameter int NUM_MASK = viu_pkg::VIU_NUM_MASK
) (
    input  wire logic                          mclk_in,
    input  wire logic                          arst_n_in,
    // Register port
    input  wire logic [3:0]                    reg_addr_in,
    input  wire logic [7:0]                    reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    output logic      [7:0]                    reg_rdata_out,
    // Source events, bit 0 highest ranked maskable
    input  wire logic [NUM_MASK-1:0]           src_event_in,
    // Core sequencer
    input  wire logic                          fetch_ready_in,
    input  wire logic [7:0]                    fetch_opcode_in,
    input  wire logic [viu_pkg::VIU_PC_W-1:0]  fetch_pc_in,
    input  wire logic                          vector_select_instruction_in,
    input  wire logic [viu_pkg::VIU_PC_W-1:0]  vis_pc_in,
    input  wire logic                          return_from_irq_instruction_in,
    input  wire logic                          clear_trap_pending_instruction_in,
    input  wire logic [7:0]                    prog_data_in,
    output logic                               jam_out,
    output logic      [7:0]                    jam_opcode_out,
    output logic                               push_out,
    output logic      [viu_pkg::VIU_PC_W-1:0]  push_addr_out,
    output logic                               branch_out,
    output logic      [viu_pkg::VIU_PC_W-1:0]  branch_addr_out,
    output logic                               prog_rd_out,
    output logic      [viu_pkg::VIU_PC_W-1:0]  prog_addr_out,
    output logic                               global_irq_enable_out
);
    import viu_pkg::*;

    typedef enum logic [2:0] {VIU_IDLE, VIU_ENTRY, VIU_VEC_A, VIU_VEC_B, VIU_VEC_C} viu_state_t;

    viu_state_t                 state_q;
    logic [2:0]                 cnt_q;
    logic [NUM_MASK-1:0]        enable_q;
    logic [NUM_MASK-1:0]        pend_q;
    logic                       gie_q;
    logic                       st_pend_q;
    logic [6:0]                 vec_hi_q;
    logic [7:0]                 rdata_q;
    logic                       jam_q;
    logic [7:0]                 jam_op_q;
    logic                       push_q;
    logic                       branch_q;
    logic                       prd_q;
    logic [VIU_PC_W-1:0]        push_addr_q;
    logic [VIU_PC_W-1:0]        branch_addr_q;
    logic [VIU_PC_W-1:0]        paddr_q;

    logic [NUM_MASK-1:0]        active;
    logic                       trap_fetch;
    logic                       take_mask;
    logic                       take;
    logic                       pend_clr_wr;
    logic [3:0]                 win_slot;
    logic [6:0]                 table_page;

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    assign active      = enable_q & pend_q;
    assign trap_fetch  = (state_q == VIU_IDLE) && fetch_ready_in
                         && (fetch_opcode_in == VIU_TRAP_OPCODE);
    // Trap pending masks all maskable entries, so only a new trap gets in
    assign take_mask   = (state_q == VIU_IDLE) && fetch_ready_in && gie_q
                         && (|active) && !st_pend_q && !trap_fetch;
    assign take        = take_mask || trap_fetch;
    assign pend_clr_wr = reg_wr_in && (reg_addr_in == VIU_REG_PENDING);

    always_comb begin
        win_slot = VIU_SLOT_DEFAULT;
        for (int i = NUM_MASK - 1; i >= 0; i--) begin
            if (active[i]) begin
                win_slot = VIU_SLOT_TABLE[4*i +: 4];
            end
        end
        if (st_pend_q) begin
            win_slot = VIU_SLOT_TRAP;
        end
    end

    // Last address of a page puts the table in the next page
    assign table_page = (vis_pc_in[7:0] == VIU_PAGE_LAST) ? vis_pc_in[14:8] + 7'h01
                                                           : vis_pc_in[14:8];

    // ------------------------------------------------------------
    // Pending and enable state
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_MASK; g++) begin : g_src
            // Set wins over a software clear in the same cycle
            always_ff @(posedge mclk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    pend_q[g] <= VIU_PENDING_RST[g];
                end else if (src_event_in[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (pend_clr_wr && reg_wdata_in[g]) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enable_q <= VIU_ENABLE_RST[NUM_MASK-1:0];
        end else if (reg_wr_in && reg_addr_in == VIU_REG_ENABLE) begin
            enable_q <= reg_wdata_in[NUM_MASK-1:0];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gie_q <= VIU_GIE_RST;
        end else if (take_mask) begin
            gie_q <= 1'b0;
        end else if (return_from_irq_instruction_in) begin
            gie_q <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == VIU_REG_CTRL) begin
            gie_q <= reg_wdata_in[VIU_CTRL_GIE_BIT];
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_pend_q <= 1'b0;
        end else if (trap_fetch) begin
            st_pend_q <= 1'b1;
        end else if (clear_trap_pending_instruction_in) begin
            st_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                VIU_REG_ENABLE:  rdata_q <= 8'(enable_q);
                VIU_REG_PENDING: rdata_q <= 8'(pend_q);
                VIU_REG_CTRL:    rdata_q <= {7'h00, gie_q};
                VIU_REG_STATUS:  rdata_q <= {7'h00, state_q != VIU_IDLE};
                default:         rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Entry sequence and vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= VIU_IDLE;
            cnt_q   <= 3'h0;
        end else begin
            case (state_q)
                VIU_IDLE: begin
                    cnt_q <= 3'h0;
                    if (take) begin
                        state_q <= VIU_ENTRY;
                    end else if (vector_select_instruction_in) begin
                        state_q <= VIU_VEC_A;
                    end
                end
                VIU_ENTRY: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == VIU_BRANCH_CNT) begin
                        state_q <= VIU_IDLE;
                    end
                end
                VIU_VEC_A: state_q <= VIU_VEC_B;
                VIU_VEC_B: state_q <= VIU_VEC_C;
                VIU_VEC_C: state_q <= VIU_IDLE;
                default:   state_q <= VIU_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            jam_q       <= 1'b0;
            push_q      <= 1'b0;
            push_addr_q <= '0;
        end else begin
            jam_q  <= take_mask;
            push_q <= (state_q == VIU_ENTRY) && (cnt_q == VIU_PUSH_CNT);
            if (take) begin
                push_addr_q <= fetch_pc_in;
            end
        end
    end

    // Opcode held in a flop so every output leaves the block registered
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            jam_op_q <= 8'h00;
        end else begin
            jam_op_q <= VIU_TRAP_OPCODE;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prd_q    <= 1'b0;
            paddr_q  <= '0;
            vec_hi_q <= 7'h00;
        end else begin
            prd_q <= 1'b0;
            if (state_q == VIU_IDLE && !take && vector_select_instruction_in) begin
                prd_q   <= 1'b1;
                paddr_q <= {table_page, VIU_TABLE_BASE + {3'h0, win_slot, 1'b0}};
            end else if (state_q == VIU_VEC_A) begin
                prd_q   <= 1'b1;
                paddr_q <= paddr_q + 15'h0001;
            end
            if (state_q == VIU_VEC_B) begin
                vec_hi_q <= prog_data_in[6:0];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            branch_q      <= 1'b0;
            branch_addr_q <= '0;
        end else begin
            branch_q <= 1'b0;
            if (state_q == VIU_ENTRY && cnt_q == VIU_BRANCH_CNT) begin
                branch_q      <= 1'b1;
                branch_addr_q <= VIU_ENTRY_ADDR;
            end else if (state_q == VIU_VEC_C) begin
                branch_q      <= 1'b1;
                branch_addr_q <= {vec_hi_q, prog_data_in};
            end
        end
    end

    assign reg_rdata_out         = rdata_q;
    assign jam_out               = jam_q;
    assign jam_opcode_out        = jam_op_q;
    assign push_out              = push_q;
    assign push_addr_out         = push_addr_q;
    assign branch_out            = branch_q;
    assign branch_addr_out       = branch_addr_q;
    assign prog_rd_out           = prd_q;
    assign prog_addr_out         = paddr_q;
    assign global_irq_enable_out = gie_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    sequence entry_s;
        take ##0 (state_q == VIU_IDLE);
    endsequence

    sequence push_then_branch_s;
        ##4 push_q ##3 (branch_q && branch_addr_q == VIU_ENTRY_ADDR);
    endsequence

    jam_on_take_a: assert property (take_mask |=> jam_q && jam_opcode_out == 8'h00)
        else $error("trap opcode not jammed after take");
    entry_steps_a: assert property (entry_s |-> push_then_branch_s)
        else $error("entry push or branch to 00ff mistimed");
    gie_clear_a: assert property (take_mask |=> !gie_q && $past(gie_q))
        else $error("global enable not cleared on entry");
    gie_block_a: assert property (!gie_q && !trap_fetch |-> !take)
        else $error("maskable entry with global enable low");
    return_from_irq_instruction_gie_a: assert property (return_from_irq_instruction_in && !take_mask |=> gie_q)
        else $error("return did not set global enable");
    trap_only_a: assert property (st_pend_q |-> !take_mask)
        else $error("maskable entry during trap service");
    trap_keep_gie_a: assert property (trap_fetch |=> gie_q == $past(gie_q) && st_pend_q)
        else $error("trap changed global enable or missed flag");
    clear_trap_pending_instruction_clear_a: assert property (clear_trap_pending_instruction_in && !trap_fetch
                                   |=> !st_pend_q)
        else $error("trap pending not cleared");
    pend_hold_a: assert property (!pend_clr_wr |=> (pend_q & $past(pend_q)) == $past(pend_q))
        else $error("pending bit dropped without software clear");
    default_vec_a: assert property (state_q == VIU_IDLE && !take
                                    && vector_select_instruction_in && !(|active) && !st_pend_q
                                    |=> prd_q && paddr_q[7:0] == 8'he0)
        else $error("default vector slot wrong");
    trap_vec_a: assert property (state_q == VIU_IDLE && !take
                                 && vector_select_instruction_in && st_pend_q
                                 |=> paddr_q[7:0] == 8'hfe ##1 paddr_q[7:0] == 8'hff)
        else $error("trap vector slot wrong");
    edge_vec_a: assert property (state_q == VIU_IDLE && !take && vector_select_instruction_in
                                 && active[0] && !st_pend_q |=> paddr_q[7:0] == 8'hfa)
        else $error("edge pin vector slot wrong");

    // ------------------------------------------------------------
    // Vector select and entry checks
    // ------------------------------------------------------------
    sequence vsel_start_s;
        (state_q == VIU_IDLE) && !take && vector_select_instruction_in;
    endsequence

    sequence vsel_fetch_s;
        ##1 prd_q ##1 prd_q ##2 branch_q;
    endsequence

    vec_steps_a: assert property (vsel_start_s |-> vsel_fetch_s)
        else $error("vector fetch steps mistimed");

    vec_pair_a: assert property (vsel_start_s
                                 |=> ##1 paddr_q == $past(paddr_q) + 15'h0001)
        else $error("low vector byte not at next address");

    vec_join_a: assert property (vsel_start_s
                                 |=> ##3 branch_addr_q == {$past(prog_data_in[6:0], 2),
                                                           $past(prog_data_in)})
        else $error("vector bytes joined wrongly");

    page_same_a: assert property (vsel_start_s ##0 (vis_pc_in[7:0] != VIU_PAGE_LAST)
                                  |=> paddr_q[14:8] == $past(vis_pc_in[14:8]))
        else $error("vector table not in select page");

    page_next_a: assert property (vsel_start_s ##0 (vis_pc_in[7:0] == VIU_PAGE_LAST)
                                  |=> paddr_q[14:8] == $past(vis_pc_in[14:8]) + 7'h01)
        else $error("vector table not in next page");

    trap_entry_a: assert property (trap_fetch
                                   |=> state_q == VIU_ENTRY && !jam_q)
        else $error("trap fetch did not start entry");

    mask_take_a: assert property ((state_q == VIU_IDLE) && fetch_ready_in && gie_q
                                  && (|active) && !st_pend_q
                                  && (fetch_opcode_in != VIU_TRAP_OPCODE)
                                  |=> jam_q && state_q == VIU_ENTRY)
        else $error("active source not taken at fetch");

    busy_refuse_a: assert property (state_q != VIU_IDLE |=> !jam_q)
        else $error("entry taken while sequence busy");

    pend_set_a: assert property (|src_event_in
                                 |=> (pend_q & $past(src_event_in)) == $past(src_event_in))
        else $error("source event did not set pending");
endmodule

//--- sim/viu_prog_mem.sv
// Program memory model that answers the unit's vector table reads
`timescale 1ns/100ps
module viu_prog_mem (
    input  wire logic        mclk_in,
    input  wire logic        arst_n_in,
    input  wire logic        prog_rd_in,
    input  wire logic [14:0] prog_addr_in,
    output logic      [7:0]  prog_data_out
);
    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Byte is a fixed scramble of its address, so either byte of a vector
    // fetched from the wrong place shows. Outside the answer cycle the bus
    // toggles every cycle, so a stale byte can never pass for a fresh one.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prog_data_out <= 8'h00;
        end else if (prog_rd_in) begin
            prog_data_out <= prog_addr_in[7:0] ^ {1'b0, prog_addr_in[14:8]} ^ 8'ha5;
        end else begin
            prog_data_out <= ~prog_data_out;
        end
    end
endmodule

//--- sim/vectored_interrupt_unit_tb_top.sv
// Self-checking testbench for the vectored interrupt unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module vectored_interrupt_unit_tb_top;
    import viu_pkg::*;
    logic        mclk, arst_n, wr, rd, fr, vector_select_instruction, return_from_irq_instruction, ctp, rd_q;
    logic        jam, psh, br, prd, global_irq_enable;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, ev, op, pdata, jop, w8, en, evm, r;
    logic [14:0] fpc, vpc, pshaddr, braddr, praddr, w15, pcv;
    logic [7:0]  q_rd[$];
    logic [7:0]  q_jam[$];
    logic [14:0] q_psh[$];
    logic [14:0] q_br[$];
    logic [14:0] q_prd[$];
    logic [7:0]  slots[8] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hea, 8'he8, 8'he2};
    int          failures;
    int          compares;

    viu_core u_dut (
        .mclk_in(mclk), .arst_n_in(arst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .src_event_in(ev),
        .fetch_ready_in(fr), .fetch_opcode_in(op), .fetch_pc_in(fpc),
        .vector_select_instruction_in(vector_select_instruction), .vis_pc_in(vpc),
        .return_from_irq_instruction_in(return_from_irq_instruction), .clear_trap_pending_instruction_in(ctp),
        .prog_data_in(pdata), .jam_out(jam), .jam_opcode_out(jop), .push_out(psh),
        .push_addr_out(pshaddr), .branch_out(br), .branch_addr_out(braddr),
        .prog_rd_out(prd), .prog_addr_out(praddr), .global_irq_enable_out(global_irq_enable)
    );
    viu_prog_mem u_mem (
        .mclk_in(mclk), .arst_n_in(arst_n), .prog_rd_in(prd), .prog_addr_in(praddr),
        .prog_data_out(pdata)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    // Sampled on the falling edge, clear of the edge that launches results.
    // A result with no note waiting compares against unknown and fails.
    always @(negedge mclk) begin
        if (rd_q === 1'b1) begin
            w8 = q_rd.size() ? q_rd.pop_front() : 'x;
            `CHK("reg_rdata", w8, rdata)
        end
        rd_q = rd;
        if (jam === 1'b1) begin
            w8 = q_jam.size() ? q_jam.pop_front() : 'x;
            `CHK("jam_opcode", w8, jop)
        end
        if (psh === 1'b1) begin
            w15 = q_psh.size() ? q_psh.pop_front() : 'x;
            `CHK("push_addr", w15, pshaddr)
        end
        if (br === 1'b1) begin
            w15 = q_br.size() ? q_br.pop_front() : 'x;
            `CHK("branch_addr", w15, braddr)
        end
        if (prd === 1'b1) begin
            w15 = q_prd.size() ? q_prd.pop_front() : 'x;
            `CHK("prog_addr", w15, praddr)
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] x);
        q_rd.push_back(x);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
    endtask
    task automatic ev_pulse(input logic [7:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
    endtask
    task automatic instr(input logic rt, input logic ct);
        @(posedge mclk);
        return_from_irq_instruction <= rt;
        ctp  <= ct;
        @(posedge mclk);
        return_from_irq_instruction <= 1'b0;
        ctp  <= 1'b0;
    endtask
    // Kind 0 must be refused, 1 is a maskable entry, 2 a trap entry
    task automatic fetch(input logic [7:0] o, input int kind);
        logic [14:0] pc;
        pc = 15'($urandom);
        if (kind == 1) q_jam.push_back(8'h00);
        if (kind != 0) q_psh.push_back(pc);
        if (kind != 0) q_br.push_back(15'h00ff);
        @(posedge mclk);
        fr  <= 1'b1;
        op  <= o;
        fpc <= pc;
        @(posedge mclk);
        fr  <= 1'b0;
        tick(8);
    endtask
    task automatic vsel(input logic [7:0] slot, input logic [14:0] pc);
        logic [14:0] a;
        logic [7:0]  hi;
        logic [7:0]  lo;
        a  = {pc[14:8] + 7'(pc[7:0] == 8'hff), slot};
        hi = a[7:0] ^ {1'b0, a[14:8]} ^ 8'ha5;
        lo = (a[7:0] + 8'h01) ^ {1'b0, a[14:8]} ^ 8'ha5;
        q_prd.push_back(a);
        q_prd.push_back(a + 15'h0001);
        q_br.push_back({hi[6:0], lo});
        @(posedge mclk);
        vector_select_instruction <= 1'b1;
        vpc <= pc;
        @(posedge mclk);
        vector_select_instruction <= 1'b0;
        tick(5);
    endtask
    task automatic chk_gie(input logic x);
        @(negedge mclk);
        `CHK("global_irq_enable", x, global_irq_enable)
    endtask
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        $display("[ERR] watchdog expected finish got hang");
        end_of_test();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {arst_n, wr, rd, fr, vector_select_instruction, return_from_irq_instruction, ctp} = '0;
        {addr, wdata, ev, op, fpc, vpc} = '0;
        failures = 0;
        compares = 0;
        void'($urandom(82220));
        pcv = {7'h12, 8'h34};
        tick(2);
        arst_n <= 1'b1;
        for (int k = 0; k < 4; k++) reg_rd(4'(k * 4), 8'h00);
        reg_wr(4'h0, 8'hff);
        reg_rd(4'h0, 8'hff);
        reg_wr(4'h2, 8'h55);
        reg_rd(4'h2, 8'h00);
        reg_wr(4'h0, 8'h00);
        ev_pulse(8'h08);
        reg_rd(4'h4, 8'h08);
        reg_wr(4'h0, 8'hff);
        fetch(8'h12, 0);
        reg_wr(4'h8, 8'h01);
        reg_rd(4'h8, 8'h01);
        fetch(8'h12, 1);
        chk_gie(1'b0);
        reg_rd(4'h4, 8'h08);
        fetch(8'h12, 0);
        reg_wr(4'h4, 8'hff);
        // Each source wins over a lower rank and over a disabled higher rank
        for (int i = 0; i < 8; i++) begin
            r   = 8'($urandom);
            en  = 8'hff ^ ((8'h01 << i) >> 1);
            evm = (8'h01 << i) | ((8'h01 << i) >> 1) | (r & ~((8'h02 << i) - 8'h01));
            pcv = {7'($urandom_range(126, 1)), (i == 3) ? 8'hff : 8'($urandom)};
            reg_wr(4'h0, en);
            ev_pulse(evm);
            vsel(slots[i], pcv);
            reg_wr(4'h4, 8'hff);
        end
        vsel(8'he0, pcv);
        reg_wr(4'h0, 8'hff);
        ev_pulse(8'h41);
        instr(1'b1, 1'b0);
        chk_gie(1'b1);
        fetch(8'h12, 1);
        vsel(8'hfa, pcv);
        reg_wr(4'h4, 8'h01);
        instr(1'b1, 1'b0);
        fetch(8'h12, 1);
        vsel(8'he8, pcv);
        reg_wr(4'h4, 8'h40);
        instr(1'b1, 1'b0);
        fetch(8'h12, 0);
        chk_gie(1'b1);
        fetch(8'h00, 2);
        chk_gie(1'b1);
        ev_pulse(8'h02);
        fetch(8'h12, 0);
        vsel(8'hfe, pcv);
        fetch(8'h00, 2);
        instr(1'b0, 1'b1);
        fetch(8'h12, 1);
        chk_gie(1'b0);
        tick(4);
        `CHK("notes_left", 0, q_rd.size() + q_jam.size() + q_psh.size() + q_br.size() + q_prd.size())
        end_of_test();
    end
endmodule
